// >>> logic/gos_regs.vh
// constants for the output sequencer: timing counts and sentence order
`ifndef GOS_REGS_VH
`define GOS_REGS_VH
`define GOS_CLK_HZ           20000000
`define GOS_BAUD             9600
`define GOS_BAUD_DIV         (`GOS_CLK_HZ / `GOS_BAUD)
`define GOS_PERIOD_S         1
`define GOS_PERIOD_CYC       (`GOS_CLK_HZ * `GOS_PERIOD_S)
`define GOS_PULSE_US         500
`define GOS_PULSE_CYC        ((`GOS_CLK_HZ / 1000000) * `GOS_PULSE_US)
`define GOS_HALF_CYC         (`GOS_PERIOD_CYC / 2)
`define GOS_SENT_MAX         80
`define GOS_BURST_MAX        880
`define GOS_NUM_SENT         12
`define GOS_SID_POS          4'h0
`define GOS_SID_VEL          4'h1
`define GOS_SID_HK           4'h2
`define GOS_SID_GGA          4'h3
`define GOS_SID_GSA          4'h4
`define GOS_SID_GLL          4'h5
`define GOS_SID_RMC          4'h6
`define GOS_SID_VTG          4'h7
`define GOS_SID_GSV1         4'h8
`define GOS_SID_GSV4         4'hB
`define GOS_FIX_NONE         2'h0
`define GOS_FIX_BLINK        2'h1
`define GOS_FIX_HIGH         2'h2
`define GOS_VEL_LIMIT_MPS    500
`endif

// >>> logic/gos_text_mem.v
// sentence text store, one byte per entry, registered read
module gos_text_mem #(
	parameter AW = 10
) (
	// clock
	input  wire          clk,
	// write port
	input  wire          wr_en,
	input  wire [AW-1:0] wr_addr,
	input  wire [7:0]    wr_data,
	// read port
	input  wire [AW-1:0] rd_addr,
	output reg  [7:0]    rd_data
);
	reg [7:0] mem [0:(1<<AW)-1];

	always @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule // gos_text_mem

// >>> logic/gos_output_sequencer.v
// per-period sentence burst, time-mark pulse and fix indicator
`include "gos_regs.vh"
module gos_output_sequencer #(
	parameter PERIOD_CYC = `GOS_PERIOD_CYC,
	parameter PULSE_CYC  = `GOS_PULSE_CYC,
	parameter BAUD_DIV   = `GOS_BAUD_DIV,
	parameter ENG_MODEL  = 0
) (
	// clock and reset
	input  wire        clk,
	input  wire        arst_n,
	// navigation state
	input  wire        fix_valid,
	input  wire        fix_partial,
	input  wire [15:0] velocity_mps,
	// sentence text load: slot 0..11, 80 bytes per slot, length per slot
	input  wire        text_wr,
	input  wire [3:0]  text_slot,
	input  wire [6:0]  text_idx,
	input  wire [7:0]  text_byte,
	input  wire        len_wr,
	input  wire [6:0]  len_val,
	// serial
	input  wire        rxd,
	output reg         txd,
	// timing pins
	output reg         time_mark,
	output reg         fix_indicator,
	// status
	output reg  [31:0] mark_stamp,
	output reg         burst_busy,
	output reg         eng_model_flag,
	output reg  [15:0] velocity_clamped
);
	localparam S_IDLE  = 4'b0001;
	localparam S_FETCH = 4'b0010;
	localparam S_SEND  = 4'b0100;
	localparam S_NEXT  = 4'b1000;
	// caps sized to their targets; half period follows the parameter, not the header
	localparam [6:0]  LEN_CAP  = `GOS_SENT_MAX - 2;
	localparam [15:0] VEL_CAP  = `GOS_VEL_LIMIT_MPS;
	localparam        HALF_CYC = PERIOD_CYC / 2;

	reg [31:0] per_q;
	reg [31:0] stamp_q;
	reg        per_end;
	reg [3:0]  st_q;
	reg [3:0]  sid_q;
	reg [6:0]  ci_q;
	reg [9:0]  burst_q;
	reg [6:0]  len_q [0:`GOS_NUM_SENT-1];
	reg [6:0]  cur_len;
	reg [15:0] baud_q;
	reg [3:0]  bit_q;
	reg [9:0]  shf_q;
	reg        tx_busy;
	reg [1:0]  mode_q;
	reg        blink_q;
	reg [7:0]  term_byte;
	wire [7:0] mem_q;
	wire [10:0] wr_a;
	wire [10:0] rd_a;
	integer    i;

	// slot stride 64 + 16 = 80 bytes
	assign wr_a = {1'b0, text_slot, 6'h00} + {4'h0, text_idx} + text_slot * 11'h010;
	assign rd_a = {1'b0, sid_q, 6'h00} + {4'h0, ci_q} + sid_q * 11'h010;

	gos_text_mem #(.AW(11)) u_mem (
		.clk     (clk),
		.wr_en   (text_wr),
		.wr_addr (wr_a),
		.wr_data (text_byte),
		.rd_addr (rd_a),
		.rd_data (mem_q)
	);

	always @* begin
		per_end = (per_q == PERIOD_CYC - 1);
		cur_len = len_q[sid_q];
		if (cur_len > LEN_CAP) begin
			cur_len = LEN_CAP;
		end
		term_byte = (ci_q == cur_len) ? 8'h0D : 8'h0A;
	end

	// period counter, mark pulse, edge stamp
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			per_q      <= 32'h0;
			stamp_q    <= 32'h0;
			time_mark  <= 1'b0;
			mark_stamp <= 32'h0;
		end else begin
			per_q   <= per_end ? 32'h0 : per_q + 32'h1;
			stamp_q <= stamp_q + 32'h1;
			// only a period end starts a pulse: no short pulse right after reset
			time_mark <= per_end || (time_mark && per_q < PULSE_CYC - 1);
			if (per_end && fix_valid) begin
				mark_stamp <= stamp_q + 32'h1;
			end
		end
	end

	// fix indicator
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_q        <= `GOS_FIX_NONE;
			blink_q       <= 1'b0;
			fix_indicator <= 1'b0;
		end else begin
			if (per_end) begin
				mode_q  <= fix_valid ? `GOS_FIX_HIGH :
					(fix_partial ? `GOS_FIX_BLINK : `GOS_FIX_NONE);
				blink_q <= 1'b1;
			end else if (per_q == HALF_CYC - 1) begin
				blink_q <= 1'b0;
			end
			case (mode_q)
				`GOS_FIX_HIGH: fix_indicator <= 1'b1;
				`GOS_FIX_BLINK: fix_indicator <= blink_q;
				default: fix_indicator <= 1'b0;
			endcase
		end
	end

	// engineering variant
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			eng_model_flag   <= 1'b0;
			velocity_clamped <= 16'h0000;
		end else begin
			eng_model_flag <= (ENG_MODEL != 0);
			if (ENG_MODEL != 0 && velocity_mps > VEL_CAP) begin
				velocity_clamped <= VEL_CAP;
			end else begin
				velocity_clamped <= velocity_mps;
			end
		end
	end

	// sentence lengths
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (i = 0; i < `GOS_NUM_SENT; i = i + 1) begin
				len_q[i] <= 7'h00;
			end
		end else if (len_wr && text_slot < `GOS_NUM_SENT) begin
			len_q[text_slot] <= len_val;
		end
	end

	// burst sequencer and uart; rxd is never looked at
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q       <= S_IDLE;
			sid_q      <= 4'h0;
			ci_q       <= 7'h00;
			burst_q    <= 10'h000;
			baud_q     <= 16'h0000;
			bit_q      <= 4'h0;
			shf_q      <= 10'h3FF;
			tx_busy    <= 1'b0;
			txd        <= 1'b1;
			burst_busy <= 1'b0;
		end else begin
			if (tx_busy) begin
				if (baud_q == BAUD_DIV - 1) begin
					baud_q <= 16'h0000;
					shf_q  <= {1'b1, shf_q[9:1]};
					if (bit_q == 4'h9) begin
						tx_busy <= 1'b0;
					end
					bit_q <= bit_q + 4'h1;
				end else begin
					baud_q <= baud_q + 16'h1;
				end
			end
			txd <= tx_busy ? shf_q[0] : 1'b1;
			// busy until the last stop bit is out, not just until the sequencer idles
			burst_busy <= (st_q != S_IDLE) || tx_busy;
			case (st_q)
				S_IDLE: begin
					if (per_end) begin
						sid_q   <= `GOS_SID_POS;
						ci_q    <= 7'h00;
						burst_q <= 10'h000;
						st_q    <= S_FETCH;
					end
				end
				S_FETCH: begin
					st_q <= S_SEND;
				end
				S_SEND: begin
					if (!tx_busy) begin
						if (burst_q >= `GOS_BURST_MAX) begin
							st_q <= S_IDLE;
						end else begin
							shf_q   <= {1'b1, (ci_q < cur_len) ? mem_q : term_byte, 1'b0};
							tx_busy <= 1'b1;
							bit_q   <= 4'h0;
							baud_q  <= 16'h0000;
							burst_q <= burst_q + 10'h1;
							st_q    <= S_NEXT;
						end
					end
				end
				S_NEXT: begin
					if (ci_q == cur_len + 7'h1) begin
						ci_q <= 7'h00;
						if (sid_q == `GOS_SID_GSV4) begin
							st_q <= S_IDLE;
						end else begin
							sid_q <= sid_q + 4'h1;
							st_q  <= S_FETCH;
						end
					end else begin
						ci_q <= ci_q + 7'h1;
						st_q <= S_FETCH;
					end
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end
endmodule // gos_output_sequencer

// >>> tb/gos_props.sv
// port checker for the output sequencer
module gos_props #(
	parameter PERIOD_CYC = 8000,
	parameter PULSE_CYC  = 100,
	parameter ENG_MODEL  = 0
) (
	// clock and reset
	input wire        clk,
	input wire        arst_n,
	// stimulus
	input wire        fix_valid,
	input wire        fix_partial,
	input wire [15:0] velocity_mps,
	// results
	input wire        txd,
	input wire        time_mark,
	input wire        fix_indicator,
	input wire        burst_busy,
	input wire        eng_model_flag,
	input wire [15:0] velocity_clamped
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int H = PERIOD_CYC / 2;
	logic        seen_q;
	logic [31:0] hi_q, per_q, st_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	// counters since pulse start, pulse high time, mode stable time
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			{seen_q, hi_q, per_q, st_q} <= '0;
		end else begin
			seen_q <= seen_q | $rose(time_mark);
			hi_q   <= time_mark ? hi_q + 1 : 0;
			per_q  <= $rose(time_mark) ? 1 : per_q + 1;
			st_q   <= $changed({fix_valid, fix_partial}) ? 0 : st_q + 1;
		end
	end
	sequence s_fell; $fell(time_mark); endsequence
	property p_idle; !burst_busy |-> txd; endproperty
	a_idle: assert property (p_idle) else $error("txd low when idle");
	property p_width; s_fell |-> hi_q == PULSE_CYC; endproperty
	a_width: assert property (p_width) else $error("pulse width");
	property p_period; $rose(time_mark) && seen_q |-> per_q == PERIOD_CYC; endproperty
	a_period: assert property (p_period) else $error("pulse period");
	// slack of one cycle: pin and pulse may be registered apart
	property p_align; $changed(fix_indicator) && seen_q |-> per_q <= 1
		|| per_q >= PERIOD_CYC - 1 || (per_q >= H - 1 && per_q <= H + 1); endproperty
	a_align: assert property (p_align) else $error("fix edge off period");
	property p_high; st_q > PERIOD_CYC + 2 && fix_valid |-> fix_indicator; endproperty
	a_high: assert property (p_high) else $error("fix pin not high");
	property p_low; st_q > PERIOD_CYC + 2 && !fix_valid && !fix_partial |-> !fix_indicator;
	endproperty
	a_low: assert property (p_low) else $error("fix pin not low");
	property p_flag; $past(arst_n) |-> eng_model_flag == (ENG_MODEL != 0); endproperty
	a_flag: assert property (p_flag) else $error("variant flag");
	property p_vel; $stable(velocity_mps) [*2] |-> velocity_clamped == ((ENG_MODEL != 0
		&& velocity_mps > 16'h01F4) ? 16'h01F4 : velocity_mps); endproperty
	a_vel: assert property (p_vel) else $error("velocity limit");
endmodule // gos_props
bind gos_output_sequencer gos_props #(.PERIOD_CYC(PERIOD_CYC), .PULSE_CYC(PULSE_CYC),
	.ENG_MODEL(ENG_MODEL)) u_props (.clk(clk), .arst_n(arst_n), .fix_valid(fix_valid),
	.fix_partial(fix_partial), .velocity_mps(velocity_mps), .txd(txd), .time_mark(time_mark),
	.fix_indicator(fix_indicator), .burst_busy(burst_busy), .eng_model_flag(eng_model_flag),
	.velocity_clamped(velocity_clamped));

// >>> tb/gos_uart_mon.sv
// serial receiver model of the onboard computer
module gos_uart_mon #(
	parameter DIV = 4
) (
	// line side
	input  wire        clk,
	input  wire        txd,
	output logic       rxd,
	// decoded bytes
	output logic       stb,
	output logic [7:0] dat,
	output logic       ferr
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{stb, dat, ferr} = '0;
		forever begin
			@(negedge txd);
			repeat (DIV / 2) @(posedge clk);
			for (int i = 0; i < 8; i++) begin
				repeat (DIV) @(posedge clk);
				dat[i] = txd; // lsb first
			end
			repeat (DIV) @(posedge clk);
			ferr |= !txd; // stop bit
			stb = !stb;
		end
	end
	// noise on receive, must not disturb output
	always @(posedge clk) rxd <= 1'($urandom);
endmodule // gos_uart_mon

// >>> tb/tb_gos_output_sequencer.sv
// bench: text load, burst, pulse, fix modes, velocity
module tb_gos_output_sequencer;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int PER = 8000;
	logic        clk = 0, arst_n = 0, fv = 0, fp = 0, tw = 0, lw = 0;
	logic [15:0] vel = 0;
	logic [3:0]  slot = 0;
	logic [6:0]  idx = 0, len = 0;
	logic [7:0]  byt = 0, got [$], exp_q [$];
	logic [31:0] s0;
	wire         rxd, txd, tm, fi, busy, flag, stb, ferr;
	wire  [7:0]  dat;
	wire  [15:0] vcl;
	wire  [31:0] stamp;
	int          ln, bad_count = 0, checked = 0, cyc = 0;
	gos_output_sequencer #(.PERIOD_CYC(PER), .PULSE_CYC(100), .BAUD_DIV(4), .ENG_MODEL(1)) DUT (
		.clk(clk), .arst_n(arst_n), .fix_valid(fv), .fix_partial(fp), .velocity_mps(vel),
		.text_wr(tw), .text_slot(slot), .text_idx(idx), .text_byte(byt), .len_wr(lw),
		.len_val(len), .rxd(rxd), .txd(txd), .time_mark(tm), .fix_indicator(fi),
		.mark_stamp(stamp), .burst_busy(busy), .eng_model_flag(flag), .velocity_clamped(vcl));
	gos_uart_mon u_mon (.clk(clk), .txd(txd), .rxd(rxd), .stb(stb), .dat(dat),
		.ferr(ferr));
	initial forever #25 clk = ~clk;
	always @(stb) got.push_back(dat);
	always @(posedge clk) begin
		cyc++;
		if (cyc == 95000) begin
			bad_count++;
			stop_test();
		end
	end
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#5;
	endtask
	task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s exp %0h got %0h", nm, e, g);
		end
	endtask
	task automatic wait_mark();
		int n = 0;
		while (tm === 1'b1) tick(1);
		while (tm !== 1'b1 && n < PER + 9) begin
			tick(1);
			n++;
		end
		cmp("mark", 1, tm);
		tick(2);
	endtask
	task automatic stop_test();
		if (bad_count == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		void'($urandom(9478));
		tick(2);
		arst_n = 1;
		for (int s = 0; s < 12; s++) begin
			ln = $urandom_range(127, 75);
			for (int i = 0; i < 80; i++) begin
				byt = $urandom;
				if (i < ln && i < 78) exp_q.push_back(byt);
				{tw, slot, idx} = {1'b1, 4'(s), 7'(i)};
				tick(1);
			end
			{tw, lw, len} = {2'b01, 7'(ln)};
			tick(1);
			lw = 0;
			exp_q.push_back(8'h0D);
			exp_q.push_back(8'h0A);
		end
		exp_q = exp_q[0:879];
		fv = 1;
		wait_mark();
		got.delete();
		for (int k = 0; k < 4; k++) begin
			vel = k < 2 ? 16'(500 + k) : 16'($urandom);
			tick(3);
			cmp("vel", vel > 16'h01F4 ? 16'h01F4 : vel, vcl);
		end
		cmp("flag", 1, flag);
		for (int n = 0; n < 40000 && busy !== 1'b0; n++) tick(1);
		cmp("busy", 0, busy);
		tick(48);
		cmp("count", 880, got.size());
		foreach (exp_q[i]) cmp("byte", exp_q[i], got[i]);
		cmp("stop", 0, ferr);
		cmp("fix", 1, fi);
		wait_mark();
		s0 = stamp;
		wait_mark();
		cmp("stamp", s0 + PER, stamp);
		for (int m = 0; m < 3; m++) begin
			{fv, fp} = m == 0 ? 2'b01 : m == 1 ? 2'b00 : 2'b11;
			s0 = stamp;
			wait_mark();
			tick(PER / 4);
			cmp("fix_a", m != 1, fi);
			tick(PER / 2);
			cmp("fix_b", m == 2, fi);
			if (m == 1) cmp("hold", s0, stamp);
		end
		stop_test();
	end
endmodule // tb_gos_output_sequencer
